/* File: design/packet_repeater.sv */
// Packet addressing, receive filtering and repeat engine of a radio modem.
// Assumes byte streams synchronous to sys_clk; radio bytes at most every other cycle.
`timescale 1ns/1ps
`default_nettype none
module packet_repeater (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration
  input wire logic repeater_en,
  input wire logic tx_addr_en,
  input wire logic rx_addr_en,
  input wire logic rx_addr_to_serial,
  input wire logic [repeater_pkg::ADDR_W-1:0] primary_tx_addr,
  input wire logic [repeater_pkg::ADDR_W-1:0] secondary_tx_addr,
  input wire logic [repeater_pkg::ADDR_W-1:0] primary_rx_addr,
  input wire logic [repeater_pkg::ADDR_W-1:0] secondary_rx_addr,
  input wire logic [repeater_pkg::CHAN_W-1:0] radio_channel,
  // Serial input from terminal
  input wire logic [repeater_pkg::BYTE_W-1:0] ser_in_data,
  input wire logic ser_in_last,
  input wire logic ser_in_valid,
  output logic ser_in_ready,
  // Serial output to terminal
  output logic [repeater_pkg::BYTE_W-1:0] ser_out_data,
  output logic ser_out_valid,
  // Radio receive
  input wire logic [repeater_pkg::BYTE_W-1:0] rad_rx_data,
  input wire logic rad_rx_last,
  input wire logic rad_rx_valid,
  input wire logic [repeater_pkg::CHAN_W-1:0] rad_rx_chan,
  // Radio transmit
  output logic [repeater_pkg::BYTE_W-1:0] rad_tx_data,
  output logic rad_tx_last,
  output logic rad_tx_valid,
  output logic [repeater_pkg::CHAN_W-1:0] rad_tx_chan,
  input wire logic rad_tx_ready,
  // Status
  output logic repeat_busy
);
  import repeater_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] pos_r;
  logic [BYTE_W-1:0] hi_r, pend_byte_r, out_byte, rd_data;
  logic accept_r, sec_hit_r, pend_r, hit_p, hit_s, acc_now, sec_now, out_fire;
  logic store_now, ovf_r, rep_pend_r, rep_sec_r, mem_rd, tx_rep_r, tx_fire, fifo_valid, fifo_pop;
  logic [ADDR_W-1:0] rx_word, tx_addr_r;
  logic [REP_CNT_W-1:0] wr_cnt_r, rep_len_r, rd_cnt_r;
  logic [CHAN_W-1:0] rx_chan_r, rep_chan_r;
  logic [FIFO_W-1:0] fifo_out;
  tx_state_t tx_state_r, tx_nxt;

  // ----------------------------------------
  // Receive address filter
  // ----------------------------------------
  assign rx_word = {hi_r, rad_rx_data};
  assign hit_p = (rx_word == primary_rx_addr);
  assign hit_s = (rx_word == secondary_rx_addr);

  always_comb begin
    acc_now = accept_r;
    sec_now = sec_hit_r;
    out_fire = 1'b0;
    out_byte = rad_rx_data;
    if (!rx_addr_en) begin
      acc_now = 1'b1;
      sec_now = 1'b0;
      out_fire = rad_rx_valid;
    end else if (pos_r == 2'd0) begin
      acc_now = 1'b0;
    end else if (pos_r == 2'd1) begin
      acc_now = hit_p || hit_s;
      sec_now = !hit_p && hit_s;
      out_fire = rad_rx_valid && acc_now && rx_addr_to_serial;
      out_byte = hi_r;
    end else begin
      out_fire = rad_rx_valid && accept_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pos_r <= 2'd0;
      hi_r <= BYTE_RST;
      accept_r <= 1'b0;
      sec_hit_r <= 1'b0;
      rx_chan_r <= CHAN_RST;
    end else if (rad_rx_valid) begin
      if (pos_r == 2'd0) begin
        hi_r <= rad_rx_data;
        rx_chan_r <= rad_rx_chan;
      end
      accept_r <= acc_now;
      sec_hit_r <= sec_now;
      if (rad_rx_last) begin
        pos_r <= 2'd0;
      end else if (pos_r != 2'd2) begin
        pos_r <= pos_r + 2'd1;
      end
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  // Kept low byte goes out on the cycle after the high byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ser_out_valid <= 1'b0;
      ser_out_data <= BYTE_RST;
      pend_r <= 1'b0;
      pend_byte_r <= BYTE_RST;
    end else begin
      ser_out_valid <= out_fire || pend_r;
      if (out_fire) begin
        ser_out_data <= out_byte;
      end else if (pend_r) begin
        ser_out_data <= pend_byte_r;
      end
      pend_r <= out_fire && rx_addr_en && (pos_r == 2'd1);
      pend_byte_r <= rad_rx_data;
    end
  end

  // ----------------------------------------
  // Repeat buffer fill
  // ----------------------------------------
  // Only payload is stored; the repeat gets a fresh address on the way out
  assign store_now = repeater_en && !rep_pend_r && rad_rx_valid && acc_now &&
                     (!rx_addr_en || pos_r == 2'd2) && !ovf_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_cnt_r <= '0;
      ovf_r <= 1'b0;
    end else if (rad_rx_valid && rad_rx_last) begin
      wr_cnt_r <= '0;
      ovf_r <= 1'b0;
    end else if (rad_rx_valid && rep_pend_r) begin
      ovf_r <= 1'b1; // Started under a pending repeat: its tail alone must not repeat
    end else if (rad_rx_valid && !ovf_r && repeater_en && acc_now &&
                 (!rx_addr_en || pos_r == 2'd2)) begin
      if (wr_cnt_r == REP_CNT_W'(REP_BYTES)) begin
        ovf_r <= 1'b1;
      end else if (store_now) begin
        wr_cnt_r <= wr_cnt_r + 1'b1;
      end
    end
  end

  // Repeat is armed when an accepted reception ends and nothing else is waiting
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rep_pend_r <= 1'b0;
      rep_len_r <= '0;
      rep_sec_r <= 1'b0;
      rep_chan_r <= CHAN_RST;
    end else if (!rep_pend_r) begin
      if (repeater_en && rad_rx_valid && rad_rx_last && acc_now && !ovf_r &&
          !(store_now && wr_cnt_r == REP_CNT_W'(REP_BYTES))) begin
        rep_pend_r <= 1'b1;
        rep_len_r <= store_now ? wr_cnt_r + 1'b1 : wr_cnt_r;
        rep_sec_r <= sec_now;
        rep_chan_r <= (pos_r == 2'd0) ? rad_rx_chan : rx_chan_r;
      end
    end else if (tx_rep_r &&
                 ((tx_fire && tx_state_r == TX_REP_OUT && rd_cnt_r == rep_len_r) ||
                  (tx_fire && tx_state_r == TX_ADDR_LO && rep_len_r == '0) ||
                  (tx_state_r == TX_REP_RD && rep_len_r == '0))) begin
      rep_pend_r <= 1'b0;
    end
  end
  assign repeat_busy = rep_pend_r;
  repeat_mem #(
    .AW(REP_AW),
    .W(BYTE_W)
  ) u_mem (
    .clk(sys_clk),
    .wr_en(store_now),
    .wr_addr(wr_cnt_r[REP_AW-1:0]),
    .wr_data(rad_rx_data),
    .rd_en(mem_rd),
    .rd_addr(rd_cnt_r[REP_AW-1:0]),
    .rd_data_r(rd_data)
  );

  // ----------------------------------------
  // Serial to radio FIFO
  // ----------------------------------------
  byte_fifo #(
    .W(FIFO_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .in_data({ser_in_last, ser_in_data}),
    .in_valid(ser_in_valid),
    .in_ready(ser_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // ----------------------------------------
  // Radio transmit sequencer
  // ----------------------------------------
  assign tx_fire = !rad_tx_valid || rad_tx_ready;
  assign fifo_pop = (tx_state_r == TX_SER) && tx_fire;
  assign mem_rd = (tx_state_r == TX_REP_RD);

  always_comb begin
    tx_nxt = tx_state_r;
    case (tx_state_r)
      TX_IDLE: begin
        if (tx_fire && rep_pend_r) begin
          tx_nxt = tx_addr_en ? TX_ADDR_HI : TX_REP_RD;
        end else if (tx_fire && fifo_valid) begin
          tx_nxt = tx_addr_en ? TX_ADDR_HI : TX_SER;
        end
      end
      TX_ADDR_HI: begin
        if (tx_fire) begin
          tx_nxt = TX_ADDR_LO;
        end
      end
      TX_ADDR_LO: begin
        if (tx_fire) begin
          tx_nxt = !tx_rep_r ? TX_SER : (rep_len_r == '0) ? TX_IDLE : TX_REP_RD;
        end
      end
      TX_SER: begin
        if (tx_fire && fifo_valid && fifo_out[FIFO_W-1]) begin
          tx_nxt = TX_IDLE;
        end
      end
      TX_REP_RD: begin
        tx_nxt = (rep_len_r == '0) ? TX_IDLE : TX_REP_OUT;
      end
      TX_REP_OUT: begin
        if (tx_fire) begin
          tx_nxt = (rd_cnt_r == rep_len_r) ? TX_IDLE : TX_REP_RD;
        end
      end
      default: begin
        tx_nxt = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_state_r <= TX_IDLE;
    end else begin
      tx_state_r <= tx_nxt;
    end
  end

  // Chosen once per packet, after the last byte before it is gone, so its channel holds
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_rep_r <= 1'b0;
      tx_addr_r <= ADDR_RST;
      rd_cnt_r <= '0;
      rad_tx_chan <= CHAN_RST;
    end else if (tx_state_r == TX_IDLE && tx_fire) begin
      rd_cnt_r <= '0;
      if (rep_pend_r) begin
        tx_rep_r <= 1'b1;
        tx_addr_r <= rep_sec_r ? secondary_tx_addr : primary_tx_addr;
        rad_tx_chan <= rep_chan_r;
      end else if (fifo_valid) begin
        tx_rep_r <= 1'b0;
        tx_addr_r <= primary_tx_addr;
        rad_tx_chan <= radio_channel;
      end
    end else if (tx_state_r == TX_REP_RD && rep_len_r != '0) begin
      rd_cnt_r <= rd_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rad_tx_valid <= 1'b0;
      rad_tx_data <= BYTE_RST;
      rad_tx_last <= 1'b0;
    end else if (tx_fire) begin
      rad_tx_valid <= 1'b0;
      case (tx_state_r)
        TX_ADDR_HI: begin
          rad_tx_valid <= 1'b1;
          rad_tx_data <= tx_addr_r[ADDR_HI_MSB:ADDR_HI_LSB];
          rad_tx_last <= 1'b0;
        end
        TX_ADDR_LO: begin
          rad_tx_valid <= 1'b1;
          rad_tx_data <= tx_addr_r[ADDR_LO_MSB:ADDR_LO_LSB];
          rad_tx_last <= tx_rep_r && (rep_len_r == '0);
        end
        TX_SER: begin
          rad_tx_valid <= fifo_valid;
          rad_tx_data <= fifo_out[BYTE_W-1:0];
          rad_tx_last <= fifo_out[FIFO_W-1];
        end
        TX_REP_OUT: begin
          rad_tx_valid <= 1'b1;
          rad_tx_data <= rd_data;
          rad_tx_last <= (rd_cnt_r == rep_len_r);
        end
        default: begin
          rad_tx_valid <= 1'b0;
        end
      endcase
    end
  end
endmodule : packet_repeater
`default_nettype wire

/* File: design/repeater_pkg.sv */
// Shared constants for the packet address and repeat block.
// Assumes a single 10 MHz clock and byte-wide data streams.
package repeater_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int CHAN_W = 8;
  // Repeat buffer: 1 kB
  localparam int REP_BYTES = 1024;
  localparam int REP_AW = 10;
  localparam int REP_CNT_W = 11;
  // Serial-to-radio FIFO
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = 9;
  // Address byte order on air
  localparam int ADDR_HI_MSB = 15;
  localparam int ADDR_HI_LSB = 8;
  localparam int ADDR_LO_MSB = 7;
  localparam int ADDR_LO_LSB = 0;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_ADDR_HI = 3'b001,
    TX_ADDR_LO = 3'b010,
    TX_SER = 3'b011,
    TX_REP_RD = 3'b100,
    TX_REP_OUT = 3'b101
  } tx_state_t;
endpackage : repeater_pkg

/* File: design/byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int W = 9,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] cnt_r;
  logic [PW:0] cnt_nxt;
  logic not_full_r;
  logic push;
  logic pop;

  assign push = in_valid && not_full_r;
  assign pop = out_valid && out_ready;
  assign in_ready = not_full_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_ptr_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      not_full_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      // Registered so in_ready comes straight off a flop
      not_full_r <= (cnt_nxt != (PW+1)'(D));
    end
  end
endmodule : byte_fifo
`default_nettype wire

/* File: design/repeat_mem.sv */
// Simple dual-port byte memory with registered read data.
// Assumes one clock; read data appear one edge after rd_en.
`timescale 1ns/1ps
`default_nettype none
module repeat_mem #(
  parameter int AW = 10,
  parameter int W = 8
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data_r
);
  logic [W-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end
endmodule : repeat_mem
`default_nettype wire

/* File: verification/packet_repeater_props.sv */
// Port-level checks for the packet address and repeat block.
// Assumes it is bound to packet_repeater; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module packet_repeater_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration
  input wire logic repeater_en,
  input wire logic tx_addr_en,
  input wire logic rx_addr_en,
  input wire logic [repeater_pkg::ADDR_W-1:0] primary_tx_addr,
  input wire logic [repeater_pkg::CHAN_W-1:0] radio_channel,
  // Streams
  input wire logic ser_in_ready,
  input wire logic [repeater_pkg::BYTE_W-1:0] ser_out_data,
  input wire logic ser_out_valid,
  input wire logic [repeater_pkg::BYTE_W-1:0] rad_rx_data,
  input wire logic rad_rx_valid,
  input wire logic [repeater_pkg::BYTE_W-1:0] rad_tx_data,
  input wire logic rad_tx_last,
  input wire logic rad_tx_valid,
  input wire logic [repeater_pkg::CHAN_W-1:0] rad_tx_chan,
  input wire logic rad_tx_ready,
  input wire logic repeat_busy
);
  import repeater_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Packet position tracking
  // ----------------------------------------
  logic first_r;
  logic second_r;
  always_ff @(posedge sys_clk) begin
    if (rst) first_r <= 1'b1;
    else if (rad_tx_valid && rad_tx_ready) first_r <= rad_tx_last;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) second_r <= 1'b0;
    else if (rad_tx_valid && rad_tx_ready) second_r <= first_r && !rad_tx_last;
  end
  // Serial packets, plus the second byte of an empty repeat: a pending repeat owns the start otherwise
  sequence s_ser_start;
    rad_tx_valid && first_r && tx_addr_en && !repeat_busy;
  endsequence
  sequence s_ser_second;
    rad_tx_valid && second_r && tx_addr_en && !repeat_busy;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_serial_addr_hi: assert property (s_ser_start |->
    rad_tx_data == primary_tx_addr[ADDR_HI_MSB:ADDR_HI_LSB] && rad_tx_chan == radio_channel)
    else $error("serial packet does not open with primary high byte");
  chk_serial_addr_lo: assert property (s_ser_second |->
    rad_tx_data == primary_tx_addr[ADDR_LO_MSB:ADDR_LO_LSB])
    else $error("serial packet second byte is not primary low byte");
  chk_tx_hold: assert property (rad_tx_valid && !rad_tx_ready |=>
    rad_tx_valid && $stable(rad_tx_data) && $stable(rad_tx_last))
    else $error("radio byte changed before it was taken");
  chk_chan_hold: assert property (rad_tx_valid && !first_r |-> $stable(rad_tx_chan))
    else $error("radio channel changed inside a packet");
  chk_echo_all: assert property (!rx_addr_en && rad_rx_valid |=>
    ser_out_valid && ser_out_data == $past(rad_rx_data))
    else $error("unfiltered radio byte not echoed next cycle");
  chk_out_cause: assert property (ser_out_valid |->
    $past(rad_rx_valid) || $past(rad_rx_valid, 2))
    else $error("serial output without a recent radio byte");
  chk_mode_idle: assert property (!repeater_en && !repeat_busy |=> !repeat_busy)
    else $error("repeat started outside repeater mode");
  chk_reset_quiet: assert property ($fell(rst) |->
    !rad_tx_valid && !ser_out_valid && ser_in_ready)
    else $error("outputs not idle after reset");
endmodule : packet_repeater_props
`default_nettype wire

/* File: verification/radio_sink_model.sv */
// Radio transmit sink: takes bytes promptly, slowly, or not at all.
// Assumes the testbench reads mem, n, chan_seen and last_at by hierarchy.
`timescale 1ns/1ps
`default_nettype none
module radio_sink_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pace control
  input wire logic slow,
  input wire logic hold,
  // Radio transmit stream
  input wire logic [7:0] rad_tx_data,
  input wire logic rad_tx_last,
  input wire logic rad_tx_valid,
  input wire logic [7:0] rad_tx_chan,
  output logic rad_tx_ready
);
  logic tick_r;
  logic [7:0] mem [0:255];
  logic [7:0] chan_seen;
  int n;
  int last_at;
  // Ready from a register, so it never follows valid in one cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_r <= 1'b0;
      rad_tx_ready <= 1'b0;
      n <= 0;
      last_at <= -1;
    end else begin
      tick_r <= !tick_r;
      rad_tx_ready <= !hold && (!slow || tick_r);
      if (rad_tx_valid && rad_tx_ready) begin
        mem[n[7:0]] <= rad_tx_data;
        chan_seen <= rad_tx_chan;
        if (rad_tx_last) begin
          last_at <= n;
        end
        n <= n + 1;
      end
    end
  end
endmodule : radio_sink_model
`default_nettype wire

/* File: verification/test_packet_repeater.sv */
// Self-checking bench for packet_repeater with a radio sink model.
// Assumes package, design and sink model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_packet_repeater;
  import repeater_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, repeater_en = 1'b0, tx_addr_en = 1'b0;
  logic rx_addr_en = 1'b0, rx_addr_to_serial = 1'b0, slow = 1'b0, hold = 1'b0;
  logic [15:0] primary_tx_addr = 16'h1234, secondary_tx_addr = 16'habff;
  logic [15:0] primary_rx_addr = 16'h0a0b, secondary_rx_addr = 16'hffff;
  logic [7:0] radio_channel = 8'h03, rad_rx_chan = 8'h05;
  logic [7:0] ser_in_data = 8'h00, rad_rx_data = 8'h00;
  logic ser_in_last = 1'b0, ser_in_valid = 1'b0, rad_rx_last = 1'b0, rad_rx_valid = 1'b0;
  logic ser_in_ready, ser_out_valid, rad_tx_last, rad_tx_valid, rad_tx_ready, repeat_busy;
  logic [7:0] ser_out_data, rad_tx_data, rad_tx_chan;
  logic [7:0] so_q[$];
  int fail_count = 0, checks_done = 0, tx_base = 0, pushes;
  always #50 sys_clk = ~sys_clk;
  packet_repeater u_packet_repeater (.sys_clk, .rst, .repeater_en, .tx_addr_en, .rx_addr_en,
    .rx_addr_to_serial, .primary_tx_addr, .secondary_tx_addr, .primary_rx_addr,
    .secondary_rx_addr, .radio_channel, .ser_in_data, .ser_in_last, .ser_in_valid,
    .ser_in_ready, .ser_out_data, .ser_out_valid, .rad_rx_data, .rad_rx_last, .rad_rx_valid,
    .rad_rx_chan, .rad_tx_data, .rad_tx_last, .rad_tx_valid, .rad_tx_chan, .rad_tx_ready,
    .repeat_busy);
  radio_sink_model u_radio_sink_model (.sys_clk, .rst, .slow, .hold, .rad_tx_data,
    .rad_tx_last, .rad_tx_valid, .rad_tx_chan, .rad_tx_ready);
  // Terminal side takes every byte; no backpressure exists
  always @(posedge sys_clk) if (ser_out_valid === 1'b1) so_q.push_back(ser_out_data);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic ser_pkt(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge sys_clk);
      ser_in_valid = 1'b1;
      ser_in_data = b[i];
      ser_in_last = (i == b.size() - 1);
      while (ser_in_ready !== 1'b1) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    ser_in_valid = 1'b0;
    ser_in_last = 1'b0;
    ser_in_data = ~ser_in_data;
  endtask : ser_pkt
  // Radio bytes two cycles apart; idle data inverted so it never lingers
  task automatic rx_pkt(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge sys_clk);
      rad_rx_valid = 1'b1;
      rad_rx_data = b[i];
      rad_rx_last = (i == b.size() - 1);
      @(negedge sys_clk);
      rad_rx_valid = 1'b0;
      rad_rx_last = 1'b0;
      rad_rx_data = ~rad_rx_data;
    end
    repeat (4) @(negedge sys_clk);
  endtask : rx_pkt
  task automatic exp_so(input logic [7:0] q[$]);
    check(16'(so_q.size()), 16'(q.size()));
    foreach (q[i]) if (i < so_q.size()) check({8'h00, so_q[i]}, {8'h00, q[i]});
    so_q.delete();
  endtask : exp_so
  task automatic exp_tx(input logic [7:0] q[$], input logic [7:0] ch);
    for (int k = 0; k < 400 && u_radio_sink_model.n - tx_base < q.size(); k++)
      @(negedge sys_clk);
    repeat (6) @(negedge sys_clk);
    check(16'(u_radio_sink_model.n - tx_base), 16'(q.size()));
    foreach (q[i]) check({8'h00, u_radio_sink_model.mem[tx_base + i]}, {8'h00, q[i]});
    check({8'h00, u_radio_sink_model.chan_seen}, {8'h00, ch});
    check(16'(u_radio_sink_model.last_at), 16'(tx_base + q.size() - 1));
    tx_base = u_radio_sink_model.n;
  endtask : exp_tx
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] q[$];
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    tx_addr_en = 1'b1;
    slow = 1'b1;
    ser_pkt('{8'ha1, 8'ha2, 8'ha3});
    exp_tx('{8'h12, 8'h34, 8'ha1, 8'ha2, 8'ha3}, 8'h03);
    tx_addr_en = 1'b0;
    slow = 1'b0;
    ser_pkt('{8'hb1, 8'hb2});
    exp_tx('{8'hb1, 8'hb2}, 8'h03);
    rx_pkt('{8'h12, 8'h34, 8'hc1});
    exp_so('{8'h12, 8'h34, 8'hc1});
    rx_addr_en = 1'b1;
    rx_pkt('{8'h0a, 8'h0b, 8'hd1, 8'hd2});
    exp_so('{8'hd1, 8'hd2});
    rx_pkt('{8'hff, 8'hff, 8'hd3});
    exp_so('{8'hd3});
    rx_pkt('{8'h0a, 8'h0c, 8'hd4});
    rx_pkt('{8'h0a});
    check(16'(so_q.size()), 16'h0000);
    rx_addr_to_serial = 1'b1;
    rx_pkt('{8'h0a, 8'h0b, 8'hd5});
    exp_so('{8'h0a, 8'h0b, 8'hd5});
    repeater_en = 1'b1;
    rx_addr_to_serial = 1'b0;
    tx_addr_en = 1'b1;
    rx_pkt('{8'hff, 8'hff, 8'he1, 8'he2});
    exp_so('{8'he1, 8'he2});
    exp_tx('{8'hab, 8'hff, 8'he1, 8'he2}, 8'h05);
    tx_addr_en = 1'b0;
    rad_rx_chan = 8'h07;
    rx_pkt('{8'h0a, 8'h0b, 8'hbe, 8'hef, 8'h77});
    exp_so('{8'hbe, 8'hef, 8'h77});
    exp_tx('{8'hbe, 8'hef, 8'h77}, 8'h07);
    ser_pkt('{8'hc7});
    exp_tx('{8'hc7}, 8'h03);
    tx_addr_en = 1'b1;
    rx_pkt('{8'h0a, 8'h0b, 8'h5a});
    exp_so('{8'h5a});
    exp_tx('{8'h12, 8'h34, 8'h5a}, 8'h07);
    tx_addr_en = 1'b0;
    // One byte over the repeat buffer: forwarded, never repeated
    q = {8'h0a, 8'h0b};
    for (int i = 0; i <= REP_BYTES; i++) q.push_back(8'(i));
    rx_pkt(q);
    check({15'h0000, repeat_busy}, 16'h0000);
    check(16'(so_q.size()), 16'(REP_BYTES + 1));
    so_q.delete();
    q.delete();
    // Stalled sink: fill the buffer until it refuses, then drain
    repeater_en = 1'b0;
    hold = 1'b1;
    pushes = 0;
    @(negedge sys_clk);
    while (ser_in_ready === 1'b1 && pushes < 40) begin
      ser_in_valid = 1'b1;
      ser_in_data = 8'(pushes);
      q.push_back(8'(pushes));
      pushes++;
      @(negedge sys_clk);
    end
    ser_in_valid = 1'b0;
    check(16'(pushes >= FIFO_DEPTH && pushes < 40), 16'h0001);
    hold = 1'b0;
    ser_pkt('{8'hee});
    q.push_back(8'hee);
    exp_tx(q, 8'h03);
    summarize();
  end
  initial begin
    #2_000_000;
    fail_count++;
    summarize();
  end
endmodule : test_packet_repeater
bind packet_repeater packet_repeater_props u_packet_repeater_props (.sys_clk, .rst,
  .repeater_en, .tx_addr_en, .rx_addr_en, .primary_tx_addr, .radio_channel, .ser_in_ready,
  .ser_out_data, .ser_out_valid, .rad_rx_data, .rad_rx_valid, .rad_tx_data, .rad_tx_last,
  .rad_tx_valid, .rad_tx_chan, .rad_tx_ready, .repeat_busy);
`default_nettype wire
